// >>> inc/cosc_pkg.sv
`default_nettype none
package cosc_pkg;
   // clock and blink timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int BLINK_PERIOD_NS = 250_000_000;
   localparam int BLINK_HALF_CYCLES = BLINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int BLINK_CNT_W = 24;

   // channels and parameter block
   localparam int CHANNELS = 4;
   localparam int PRM_BYTES = 22;
   localparam logic [4:0] PRM_LAST_IDX = 5'h15;
   localparam logic [4:0] PRM_RANGE_BASE = 5'h00;
   localparam logic [4:0] PRM_FLAGS = 5'h04;
   localparam logic [4:0] PRM_FVAL_BASE = 5'h05;
   localparam int FLAG_DIAG_LSB = 0;
   localparam int FLAG_FSEL_LSB = 4;
   localparam logic [7:0] RANGE_4_20 = 8'h44;
   localparam logic [7:0] RANGE_0_21 = 8'h45;

   // current scaling in microamps
   localparam logic [15:0] UA_OFFSET_4_20 = 16'h0FA0;
   localparam logic [15:0] UA_SPAN_4_20 = 16'h3E80;
   localparam logic [15:0] UA_SPAN_0_21 = 16'h5208;

   // register word addresses
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_STATUS = 6'h01;
   localparam logic [5:0] REG_IRQ_STATUS = 6'h02;
   localparam logic [5:0] REG_IRQ_MASK = 6'h03;
   localparam logic [5:0] REG_CODE_BASE = 6'h04;
   localparam logic [5:0] REG_PRM_BASE = 6'h20;

   // register fields and reset values
   localparam int CTRL_CAL_MODE = 0;
   localparam logic CTRL_CAL_MODE_RST = 1'b0;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_OUT_EN = 3;
   localparam int ST_FAULT = 4;
   localparam int ST_CAL_RUN = 5;
   localparam int ST_DIAG_LSB = 8;
   localparam int ST_FSEL_LSB = 12;
   localparam int ST_WIDE_LSB = 16;
   localparam int IRQ_W = 6;
   localparam int IRQ_INIT_OK = 0;
   localparam int IRQ_INIT_ERR = 1;
   localparam int IRQ_COMM_LOST = 2;
   localparam int IRQ_COMM_BACK = 3;
   localparam int IRQ_FRAME = 4;
   localparam int IRQ_CAL_DONE = 5;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
   localparam logic [1:0] RD_DONE = 2'h2;

   typedef enum logic [2:0] {
      COSC_WAIT_INIT = 3'b001,
      COSC_LINKED = 3'b010,
      COSC_LOST = 3'b100
   } cosc_link_state_type;

   typedef logic [CHANNELS-1:0][15:0] cosc_code_set_type;

   typedef struct packed {
      logic [CHANNELS-1:0] wide;
      logic [CHANNELS-1:0] fsel;
      logic [CHANNELS-1:0] diag;
      cosc_code_set_type fval;
   } cosc_prm_type;

   typedef struct packed {
      logic wide;
      logic [15:0] code;
      logic [15:0] ua;
   } cosc_chan_out_type;

   // code to microamps; floor division by 65535 via shift identity
   function automatic logic [15:0] cosc_to_ua(input logic [15:0] code,
                                              input logic wide);
      logic [31:0] p;
      logic [31:0] q;
      p = 32'(code) * 32'(wide ? UA_SPAN_0_21 : UA_SPAN_4_20);
      q = (p + (p >> 16) + 32'h1) >> 16;
      cosc_to_ua = q[15:0] + (wide ? 16'h0000 : UA_OFFSET_4_20);
   endfunction : cosc_to_ua
endpackage : cosc_pkg
`default_nettype wire

// >>> hw/cosc_prm_mem.sv
`default_nettype none
module cosc_prm_mem (
   // clock
   input wire logic clk,
   // write port
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [7:0] wr_data,
   // read port
   input wire logic [4:0] rd_addr,
   output logic [7:0] rd_data_reg
);
   logic [7:0] mem [0:31];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_reg <= mem[rd_addr];
   end
endmodule : cosc_prm_mem
`default_nettype wire

// >>> hw/cosc_top.sv
// Contract
// R1: blink link lamp 4 Hz until initialised
// R2: link lamp steady on after good init
// R3: bad init data keeps link lamp blinking
// R4: blink while link lost, steady when back
// R5: running mode keeps calibration lamp off
// R6: calibration mode idle: calibration lamp blinks
// R7: calibration lamp steady while procedure runs
// R8: calibration lamp off without established link
// R9: accept 16-bit unsigned code per channel
// R10: map code linearly onto selected range
// R11: 22-byte parameter block, ranges 68/69 checked
// R12: controller pre-scales fault values to codes
// R13: per-channel bit selects hold or fault value
// R14: link fault enters fault mode automatically
// R15: outputs disabled until first output command
// R16: blink from clock counter, even split
// R17: register code, present cycle after frame; chan_out shows the code two cycles after the frame
`default_nettype none
module cosc_top #(
   parameter int BLINK_HALF_CYCLES = cosc_pkg::BLINK_HALF_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // parameter byte stream
   input wire logic prm_valid,
   input wire logic [7:0] prm_data,
   input wire logic prm_last,
   // output frames and link state
   input wire logic out_valid,
   input wire cosc_pkg::cosc_code_set_type out_codes,
   input wire logic comm_ok,
   // calibration procedure
   input wire logic cal_cmd,
   input wire logic cal_done,
   // converter side
   output cosc_pkg::cosc_chan_out_type [cosc_pkg::CHANNELS-1:0] chan_out,
   output logic out_enable,
   output logic fault_active,
   // lamps and interrupt
   output logic lamp_link,
   output logic lamp_cal,
   output logic irq
);
   cosc_pkg::cosc_link_state_type state_reg, state_next;
   cosc_pkg::cosc_prm_type prm_reg, stage_reg, stage_next;
   cosc_pkg::cosc_code_set_type code_reg, code_next;
   cosc_pkg::cosc_chan_out_type [cosc_pkg::CHANNELS-1:0] chan_reg;
   cosc_pkg::cosc_chan_out_type [cosc_pkg::CHANNELS-1:0] chan_next;
   logic [4:0] byte_idx_reg;
   logic [4:0] byte_idx_next;
   logic prm_bad_reg;
   logic prm_bad_next;
   logic byte_bad;
   logic [cosc_pkg::BLINK_CNT_W-1:0] blink_cnt_reg;
   logic blink_reg;
   logic blink_wrap;
   logic out_en_reg;
   logic cal_run_reg;
   logic cal_mode_reg;
   logic [cosc_pkg::IRQ_W-1:0] irq_status_reg;
   logic [cosc_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [cosc_pkg::IRQ_W-1:0] irq_events;
   logic [cosc_pkg::IRQ_W-1:0] irq_clear;
   logic [1:0] rd_cnt_reg;
   logic [31:0] readdata_reg;
   logic [31:0] rd_word;
   logic [7:0] mem_q;
   logic init_end;
   logic init_good;
   logic init_err;
   logic linked;
   logic frame_take;
   logic comm_lost_ev;
   logic comm_back_ev;
   logic sel_ctrl;
   logic sel_status;
   logic sel_irq_status;
   logic sel_irq_mask;
   logic sel_code;
   logic sel_prm;
   logic rd_finish;
   logic wr_take;
   logic [31:0] status_word;

   // ---------------------------------------------------------------
   // parameter block intake
   assign init_end = prm_valid && prm_last;
   assign byte_bad = (byte_idx_reg < cosc_pkg::PRM_FLAGS) &&
                     (prm_data != cosc_pkg::RANGE_4_20) &&
                     (prm_data != cosc_pkg::RANGE_0_21);
   assign init_good = init_end && !prm_bad_reg &&
                      (byte_idx_reg == cosc_pkg::PRM_LAST_IDX); // R11
   assign init_err = init_end && !init_good; // R3

   always_comb begin
      stage_next = stage_reg;
      prm_bad_next = prm_bad_reg;
      byte_idx_next = byte_idx_reg;
      if (prm_valid) begin
         prm_bad_next = prm_bad_reg || byte_bad ||
                        (byte_idx_reg > cosc_pkg::PRM_LAST_IDX);
         byte_idx_next = prm_last ? 5'h00 : byte_idx_reg + 5'h01;
         if (prm_last) begin
            prm_bad_next = 1'b0;
         end
         if (byte_idx_reg < cosc_pkg::PRM_FLAGS) begin
            stage_next.wide[byte_idx_reg[1:0]] =
               (prm_data == cosc_pkg::RANGE_0_21); // R11
         end else if (byte_idx_reg == cosc_pkg::PRM_FLAGS) begin
            stage_next.diag = prm_data[cosc_pkg::FLAG_DIAG_LSB +: 4];
            stage_next.fsel = prm_data[cosc_pkg::FLAG_FSEL_LSB +: 4]; // R13
         end else if (byte_idx_reg < cosc_pkg::PRM_FVAL_BASE + 5'h08) begin
            // fault values, high byte first; already scaled codes
            stage_next = fval_byte(stage_next,
                                   byte_idx_reg - cosc_pkg::PRM_FVAL_BASE,
                                   prm_data); // R12
         end
      end
   end

   function automatic cosc_pkg::cosc_prm_type fval_byte(
      input cosc_pkg::cosc_prm_type p, input logic [4:0] k,
      input logic [7:0] d);
      cosc_pkg::cosc_prm_type r;
      r = p;
      if (k[0]) begin
         r.fval[k[2:1]][7:0] = d;
      end else begin
         r.fval[k[2:1]][15:8] = d;
      end
      fval_byte = r;
   endfunction : fval_byte

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage_reg <= '0;
         prm_reg <= '0;
         byte_idx_reg <= 5'h00;
         prm_bad_reg <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         byte_idx_reg <= byte_idx_next;
         prm_bad_reg <= prm_bad_next;
         if (init_good) begin
            prm_reg <= stage_next; // R11
         end
      end
   end

   cosc_prm_mem u_prm_mem (
      .clk(clk),
      .wr_en(prm_valid && (byte_idx_reg <= cosc_pkg::PRM_LAST_IDX)),
      .wr_addr(byte_idx_reg),
      .wr_data(prm_data),
      .rd_addr(avs_address[4:0]),
      .rd_data_reg(mem_q)
   );

   // ---------------------------------------------------------------
   // link state
   assign linked = (state_reg == cosc_pkg::COSC_LINKED);
   assign comm_lost_ev = linked && !comm_ok;
   assign comm_back_ev = (state_reg == cosc_pkg::COSC_LOST) && comm_ok;

   always_comb begin
      case (state_reg)
         cosc_pkg::COSC_WAIT_INIT: begin
            state_next = (init_good && comm_ok) ? cosc_pkg::COSC_LINKED
                                                : cosc_pkg::COSC_WAIT_INIT;
         end
         cosc_pkg::COSC_LINKED: begin
            state_next = comm_ok ? cosc_pkg::COSC_LINKED
                                 : cosc_pkg::COSC_LOST; // R4
         end
         cosc_pkg::COSC_LOST: begin
            state_next = comm_ok ? cosc_pkg::COSC_LINKED
                                 : cosc_pkg::COSC_LOST; // R4
         end
         default: begin
            state_next = cosc_pkg::COSC_WAIT_INIT;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= cosc_pkg::COSC_WAIT_INIT;
      end else begin
         state_reg <= state_next; // R2
      end
   end

   // ---------------------------------------------------------------
   // blink generator, 4 Hz with half-period on and off
   assign blink_wrap = (blink_cnt_reg ==
      cosc_pkg::BLINK_CNT_W'(BLINK_HALF_CYCLES - 1));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         blink_cnt_reg <= '0;
         blink_reg <= 1'b0;
      end else begin
         blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + 1'b1; // R16
         if (blink_wrap) begin
            blink_reg <= !blink_reg; // R16
         end
      end
   end

   // ---------------------------------------------------------------
   // calibration procedure tracking; start wins over finish
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cal_run_reg <= 1'b0;
      end else begin
         cal_run_reg <= (cal_cmd && linked && cal_mode_reg) ||
                        (cal_run_reg && !cal_done && linked); // R7
      end
   end

   // lamps
   assign lamp_link = linked ? 1'b1 : blink_reg; // R1 R2 R3 R4
   assign lamp_cal = (!cal_mode_reg) ? 1'b0 : // R5
                     (!linked) ? 1'b0 : // R8
                     cal_run_reg ? 1'b1 : blink_reg; // R6 R7

   // ---------------------------------------------------------------
   // output codes, enable and fault mode
   assign frame_take = out_valid && linked; // R9

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_en_reg <= 1'b0;
      end else if (frame_take) begin
         out_en_reg <= 1'b1; // R15
      end
   end

   assign fault_active = out_en_reg && !linked; // R14 R15
   assign out_enable = out_en_reg;

   always_comb begin
      code_next = code_reg;
      if (frame_take) begin
         code_next = out_codes; // R17
      end
   end

   always_comb begin
      for (int c = 0; c < cosc_pkg::CHANNELS; c++) begin
         chan_next[c].wide = prm_reg.wide[c];
         chan_next[c].code = code_reg[c];
         if (!out_en_reg) begin
            chan_next[c].code = 16'h0000; // R15
         end else if (fault_active && prm_reg.fsel[c]) begin
            chan_next[c].code = prm_reg.fval[c]; // R13 R14
         end
         chan_next[c].ua = cosc_pkg::cosc_to_ua(chan_next[c].code,
                                                prm_reg.wide[c]); // R10
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         code_reg <= '0;
         chan_reg <= '0;
      end else begin
         code_reg <= code_next;
         chan_reg <= chan_next;
      end
   end

   assign chan_out = chan_reg;

   // ---------------------------------------------------------------
   // avalon-mm decode
   assign sel_ctrl = (avs_address == cosc_pkg::REG_CTRL);
   assign sel_status = (avs_address == cosc_pkg::REG_STATUS);
   assign sel_irq_status = (avs_address == cosc_pkg::REG_IRQ_STATUS);
   assign sel_irq_mask = (avs_address == cosc_pkg::REG_IRQ_MASK);
   assign sel_code = (avs_address[5:2] == cosc_pkg::REG_CODE_BASE[5:2]);
   assign sel_prm = (avs_address[5] == cosc_pkg::REG_PRM_BASE[5]) &&
                    (avs_address[4:0] <= cosc_pkg::PRM_LAST_IDX);
   assign rd_finish = avs_read && (rd_cnt_reg == cosc_pkg::RD_DONE);
   assign wr_take = avs_write && avs_byteenable[0];
   assign avs_waitrequest = avs_read && (rd_cnt_reg != cosc_pkg::RD_DONE);
   assign avs_readdata = readdata_reg;

   assign status_word = {12'h000,
                         prm_reg.wide,
                         prm_reg.fsel,
                         prm_reg.diag,
                         2'b00,
                         cal_run_reg,
                         fault_active,
                         out_en_reg,
                         state_reg};

   always_comb begin
      rd_word = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_word[cosc_pkg::CTRL_CAL_MODE] = cal_mode_reg;
      end else if (sel_status) begin
         rd_word = status_word;
      end else if (sel_irq_status) begin
         rd_word[cosc_pkg::IRQ_W-1:0] = irq_status_reg;
      end else if (sel_irq_mask) begin
         rd_word[cosc_pkg::IRQ_W-1:0] = irq_mask_reg;
      end else if (sel_code) begin
         rd_word[15:0] = chan_reg[avs_address[1:0]].code;
      end else if (sel_prm) begin
         rd_word[7:0] = mem_q;
      end
   end

   // read takes two wait cycles so memory data settles into readdata
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_cnt_reg <= 2'h0;
         readdata_reg <= 32'h0000_0000;
      end else begin
         rd_cnt_reg <= (avs_read && !rd_finish) ? rd_cnt_reg + 2'h1 : 2'h0;
         if (avs_read && (rd_cnt_reg == 2'h1)) begin
            readdata_reg <= rd_word;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cal_mode_reg <= cosc_pkg::CTRL_CAL_MODE_RST;
         irq_mask_reg <= cosc_pkg::IRQ_MASK_RST;
      end else if (wr_take) begin
         if (sel_ctrl) begin
            cal_mode_reg <= avs_writedata[cosc_pkg::CTRL_CAL_MODE];
         end
         if (sel_irq_mask) begin
            irq_mask_reg <= avs_writedata[cosc_pkg::IRQ_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt status: read clears, a new event wins
   assign irq_events = {cal_run_reg && cal_done,
                        frame_take,
                        comm_back_ev,
                        comm_lost_ev,
                        init_err,
                        init_good};
   assign irq_clear = (rd_finish && sel_irq_status) ? irq_status_reg
                                                    : '0;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_status_reg <= '0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);
endmodule : cosc_top
`default_nettype wire

// >>> test/cosc_assertions.sv
`default_nettype none
module cosc_assertions #(
   parameter int BLINK_HALF_CYCLES = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // bus handshake
   input wire logic avs_read,
   input wire logic avs_waitrequest,
   // frames and link
   input wire logic out_valid,
   input wire cosc_pkg::cosc_code_set_type out_codes,
   input wire logic comm_ok,
   // outputs
   input wire cosc_pkg::cosc_chan_out_type [cosc_pkg::CHANNELS-1:0] chan_out,
   input wire logic out_enable,
   input wire logic fault_active,
   input wire logic lamp_link,
   input wire logic lamp_cal
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [23:0] low_run_reg;
   logic [23:0] high_run_reg;

   // run lengths of the link lamp
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         low_run_reg <= 24'h000000;
         high_run_reg <= 24'h000000;
      end else begin
         low_run_reg <= lamp_link ? 24'h000000 : low_run_reg + 24'h000001;
         high_run_reg <= (lamp_link && !comm_ok) ?
            high_run_reg + 24'h000001 : 24'h000000;
      end
   end

   function automatic logic [15:0] ua_of(input logic [15:0] c,
                                         input logic w);
      longint p;
      p = w ? c * 64'd21000 / 64'd65535 : 64'd4000 + c * 64'd16000 / 64'd65535;
      ua_of = 16'(p);
   endfunction : ua_of

   sequence s_rd_wait;
      avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   sequence s_frame_taken;
      (out_valid && out_enable && !fault_active) ##1 !fault_active;
   endsequence

   AST_RD_WAIT: assert property ($rose(avs_read) |-> s_rd_wait)
      else $error("read answer not after two wait cycles");
   AST_FAULT_EN: assert property (fault_active |-> out_enable)
      else $error("fault mode without enabled outputs");
   AST_EN_CAUSE: assert property ($rose(out_enable) |-> $past(out_valid))
      else $error("outputs enabled without a frame");
   AST_LOST_FAULT: assert property (!comm_ok && out_enable |=> fault_active)
      else $error("link loss did not enter fault mode");
   AST_CAL_DROP: assert property (!comm_ok |=> !lamp_cal)
      else $error("calibration lamp lit without link");
   AST_OFF_ZERO: assert property (!out_enable |->
      chan_out[0].code == 16'h0000 && chan_out[3].code == 16'h0000)
      else $error("code driven before first frame");
   AST_FRAME: assert property (s_frame_taken |=>
      chan_out[1].code == $past(out_codes[1], 2))
      else $error("frame code not applied two cycles later");
   AST_UA_MAP: assert property (!$past(reset) |->
      chan_out[2].ua == ua_of(chan_out[2].code, chan_out[2].wide))
      else $error("current does not match code and range");
   AST_BLINK_LOW: assert property (low_run_reg <= BLINK_HALF_CYCLES + 1)
      else $error("link lamp dark too long");
   AST_BLINK_HIGH: assert property (high_run_reg <= BLINK_HALF_CYCLES + 2)
      else $error("link lamp steady while link down");
endmodule : cosc_assertions

bind cosc_top cosc_assertions #(
   .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) i_cosc_assertions (
   .clk(clk), .reset(reset), .avs_read(avs_read),
   .avs_waitrequest(avs_waitrequest), .out_valid(out_valid),
   .out_codes(out_codes), .comm_ok(comm_ok), .chan_out(chan_out),
   .out_enable(out_enable), .fault_active(fault_active),
   .lamp_link(lamp_link), .lamp_cal(lamp_cal)
);
`default_nettype wire

// >>> test/cosc_ctrl_model.sv
`default_nettype none
module cosc_ctrl_model (
   // clock
   input wire logic clk,
   // parameter stream
   output logic prm_valid,
   output logic [7:0] prm_data,
   output logic prm_last,
   // frames, link, calibration
   output logic out_valid,
   output cosc_pkg::cosc_code_set_type out_codes,
   output logic comm_ok,
   output logic cal_cmd,
   output logic cal_done
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {prm_valid, prm_last, out_valid, cal_cmd, cal_done} = 5'h00;
      prm_data = 8'h00;
      out_codes = '0;
      comm_ok = 1'b1;
   end

   task automatic send_prm(input logic [7:0] b [24], input int n);
      for (int i = 0; i < n; i++) begin
         prm_valid <= 1'b1;
         prm_data <= b[i];
         prm_last <= (i == n - 1);
         @(posedge clk);
      end
      prm_valid <= 1'b0;
      prm_last <= 1'b0;
      prm_data <= ~b[n-1];
      @(posedge clk);
   endtask : send_prm

   task automatic send_frame(input cosc_pkg::cosc_code_set_type c);
      out_valid <= 1'b1;
      out_codes <= c;
      @(posedge clk);
      out_valid <= 1'b0;
      out_codes <= ~c;
      @(posedge clk);
   endtask : send_frame

   task automatic pulse(input logic fin);
      cal_cmd <= !fin;
      cal_done <= fin;
      @(posedge clk);
      cal_cmd <= 1'b0;
      cal_done <= 1'b0;
      @(posedge clk);
   endtask : pulse

   task automatic set_link(input logic v);
      comm_ok <= v;
      @(posedge clk);
   endtask : set_link
endmodule : cosc_ctrl_model
`default_nettype wire

// >>> test/tb_cosc_top.sv
`default_nettype none
module tb_cosc_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HC = 5;
   logic clk, reset, avs_read, avs_write, avs_waitrequest, prm_valid;
   logic prm_last, out_valid, comm_ok, cal_cmd, cal_done, out_enable;
   logic fault_active, lamp_link, lamp_cal, irq;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, d;
   logic [7:0] prm_data;
   cosc_pkg::cosc_code_set_type out_codes, fv, last;
   cosc_pkg::cosc_chan_out_type [cosc_pkg::CHANNELS-1:0] chan_out;
   int mismatches, checks, seed;
   logic [7:0] pb [24];
   logic [3:0] fsel, wide;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   cosc_top #(.BLINK_HALF_CYCLES(HC)) i_cosc_top (
      .clk(clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .prm_valid(prm_valid), .prm_data(prm_data), .prm_last(prm_last),
      .out_valid(out_valid), .out_codes(out_codes), .comm_ok(comm_ok),
      .cal_cmd(cal_cmd), .cal_done(cal_done), .chan_out(chan_out),
      .out_enable(out_enable), .fault_active(fault_active),
      .lamp_link(lamp_link), .lamp_cal(lamp_cal), .irq(irq)
   );

   cosc_ctrl_model i_cosc_ctrl_model (
      .clk(clk), .prm_valid(prm_valid), .prm_data(prm_data),
      .prm_last(prm_last), .out_valid(out_valid), .out_codes(out_codes),
      .comm_ok(comm_ok), .cal_cmd(cal_cmd), .cal_done(cal_done)
   );

   task automatic check(input string n, input logic [31:0] s,
                        input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   task automatic tmo(input int n);
      if (n >= 100) begin
         mismatches++;
         give_verdict();
      end
   endtask : tmo

   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      tmo(n);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus

   function automatic logic lamp(input logic w);
      lamp = w ? lamp_cal : lamp_link;
   endfunction : lamp

   // second run is a whole half period
   task automatic blink_chk(input logic w);
      int n;
      logic v;
      for (int k = 0; k < 2; k++) begin
         v = lamp(w);
         n = 0;
         while (lamp(w) === v && n < 100) begin
            @(posedge clk);
            n++;
         end
         tmo(n);
      end
      check("blink run", n, HC);
   endtask : blink_chk

   task automatic steady(input logic w, input logic e);
      repeat (3 * HC) begin
         @(posedge clk);
         check("lamp level", {31'h0, lamp(w)}, {31'h0, e});
      end
   endtask : steady

   function automatic logic [31:0] exp_ua(input logic [15:0] c,
                                          input logic w);
      longint p;
      p = w ? c * 64'd21000 / 64'd65535 : 64'd4000 + c * 64'd16000 / 64'd65535;
      exp_ua = 32'(p);
   endfunction : exp_ua

   task automatic make_prm();
      for (int i = 0; i < 24; i++) begin
         pb[i] = 8'($random(seed));
      end
      for (int c = 0; c < 4; c++) begin
         wide[c] = pb[c][0];
         pb[c] = wide[c] ? cosc_pkg::RANGE_0_21 : cosc_pkg::RANGE_4_20;
         fv[c] = {pb[5 + 2 * c], pb[6 + 2 * c]};
      end
      fsel = pb[4][7:4];
   endtask : make_prm

   initial begin
      seed = 10847;
      mismatches = 0;
      checks = 0;
      reset = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      bus(1'b0, cosc_pkg::REG_STATUS, 32'h0);
      check("state", d & 32'h00000007, 32'h00000001);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, i == 3 ? 6'h10 : 6'(i * 2 + 1) & 6'h03, 32'h0);
         check("reset value", d & 32'hFFFFFFF8, 32'h00000000);
      end
      blink_chk(1'b0);
      steady(1'b1, 1'b0);
      $display("test power-up done");
      bus(1'b1, cosc_pkg::REG_IRQ_MASK, 32'h0000003F);
      for (int k = 0; k < 2; k++) begin
         make_prm();
         pb[0] = k ? cosc_pkg::RANGE_4_20 : 8'h46;
         i_cosc_ctrl_model.send_prm(pb, 22 + k);
         check("irq", {31'h0, irq}, 32'h1);
         bus(1'b0, cosc_pkg::REG_IRQ_STATUS, 32'h0);
         check("irq status", d, 32'h00000002);
         check("irq clear", {31'h0, irq}, 32'h0);
         blink_chk(1'b0);
      end
      $display("test bad block done");
      make_prm();
      i_cosc_ctrl_model.send_prm(pb, 22);
      steady(1'b0, 1'b1);
      bus(1'b0, cosc_pkg::REG_IRQ_STATUS, 32'h0);
      check("init ok", d, 32'h00000001);
      bus(1'b0, cosc_pkg::REG_STATUS, 32'h0);
      check("ranges", (d >> 12) & 32'hFF, {24'h0, wide, fsel});
      bus(1'b0, cosc_pkg::REG_PRM_BASE + 6'h04, 32'h0);
      check("prm byte", d, {24'h0, pb[4]});
      $display("test good block done");
      for (int i = 0; i < 6; i++) begin
         for (int c = 0; c < 4; c++) begin
            last[c] = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($random(seed));
         end
         i_cosc_ctrl_model.send_frame(last);
         @(posedge clk);
         for (int c = 0; c < 4; c++) begin
            check("code", {16'h0, chan_out[c].code}, {16'h0, last[c]});
            check("ua", {16'h0, chan_out[c].ua}, exp_ua(last[c], wide[c]));
            check("wide", chan_out[c].wide, wide[c]);
         end
      end
      bus(1'b0, cosc_pkg::REG_CODE_BASE + 6'h03, 32'h0);
      check("code reg", d, {16'h0, last[3]});
      $display("test frames done");
      bus(1'b0, cosc_pkg::REG_IRQ_STATUS, 32'h0);
      bus(1'b1, cosc_pkg::REG_CTRL, 32'h00000001);
      blink_chk(1'b1);
      i_cosc_ctrl_model.pulse(1'b0);
      steady(1'b1, 1'b1);
      i_cosc_ctrl_model.pulse(1'b1);
      check("cal irq", {31'h0, irq}, 32'h1);
      blink_chk(1'b1);
      $display("test calibration done");
      i_cosc_ctrl_model.set_link(1'b0);
      repeat (4) @(posedge clk);
      check("fault", {31'h0, fault_active}, 32'h1);
      for (int c = 0; c < 4; c++) begin
         check("fault code", {16'h0, chan_out[c].code},
               {16'h0, fsel[c] ? fv[c] : last[c]});
      end
      steady(1'b1, 1'b0);
      blink_chk(1'b0);
      i_cosc_ctrl_model.set_link(1'b1);
      repeat (2) @(posedge clk);
      check("fault off", {31'h0, fault_active}, 32'h0);
      steady(1'b0, 1'b1);
      $display("test link loss done");
      give_verdict();
   end
endmodule : tb_cosc_top
`default_nettype wire
